/* hw/itc_regs.sv */
// Local design decision: the AHB-Lite slave port.
`include "itc_map.svh"

module itc_regs
  import itc_pkg::*;
#(
  parameter int TICK_CYCLES = `ITC_TICK_US * `ITC_CLK_MHZ
) (
  // Clock, reset and enable.
  input  wire logic          clock,
  input  wire logic          nrst,
  input  wire logic          ce,
  // AHB-Lite slave.
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic               hreadyout,
  output logic               hresp,
  output logic [31:0]        hrdata,
  // Engine events and companion strobes.
  input  wire itc_events_t   events,
  input  wire logic          memory_reg_write,
  input  wire logic [15:0]   frame_byte_pair,
  input  wire logic          tx2_matrix_bit,
  // Pins from outside the clock domain.
  input  wire logic          frame_sync,
  input  wire logic          external_input_six,
  // Outputs.
  output logic               interrupt_pin,
  output logic               watchdog_output_pin,
  output logic               memory_init_start,
  output logic               matrix_input_six,
  output logic [15:0]        memory_word,
  output itc_queue_map_t     queue_map,
  output itc_config_t        config_out
);

  // Register state.
  logic [15:0]              interrupt_queue_size_reg;
  logic [`ITC_NFLAGS-1:0]   interrupt_flags_reg;
  logic [`ITC_NFLAGS-1:0]   interrupt_flags_next;
  logic [15:0]              interrupt_mask_reg;
  logic [15:0]              watchdog_timer_period_reg;
  logic [15:0]              general_config_two_reg;
  logic [15:0]              initiate_block_base_reg;
  logic                     timer_disable_option_reg;

  // Bus data-phase state.
  logic                     wr_pend_reg;
  logic [8:0]               wr_idx_reg;

  // Synchronisers and time base.
  logic [1:0]               fs_sync_reg;
  logic                     fs_last_reg;
  logic                     fs_half_reg;
  logic [1:0]               external_input_six_sync_reg;
  logic [14:0]              div_cnt_reg;
  logic [14:0]              tick_cnt_reg;
  logic                     tick;
  logic                     fs_rise;
  logic                     timer_event;
  logic                     wd_clear;
  logic [14:0]              limit;

  // Bus decode terms.
  logic                     addr_phase;
  logic [8:0]               addr_idx;
  logic                     read_flags;

  // Word index of a byte address; unaligned bits are dropped.
  function automatic logic [8:0] word_index(input logic [31:0] a);
    word_index = a[10:2];
  endfunction : word_index

  // Size in words of a queue from its code and unit.
  function automatic logic [10:0] queue_words(input logic [2:0] code,
                                              input logic [10:0] unit);
    queue_words = 11'((4'(code) + 4'h1) * unit);
  endfunction : queue_words

  // A transfer is taken when selected, active and the bus is ready.
  assign addr_phase = hsel && htrans[1] && hready;
  assign addr_idx   = word_index(haddr);
  assign read_flags = addr_phase && !hwrite &&
                      (addr_idx == `ITC_IDX_FLAGS);

  // Bus responses: zero wait states, always OKAY.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end else if (ce) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Write address captured for the following data phase.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_pend_reg <= 1'b0;
      wr_idx_reg  <= 9'h000;
    end else if (ce) begin
      if (hready) begin
        wr_pend_reg <= addr_phase && hwrite;
        wr_idx_reg  <= addr_idx;
      end
    end
  end

  // Read data is captured at the address phase and held in the data phase.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hrdata <= 32'h0000_0000;
    end else if (ce && addr_phase && !hwrite) begin
      unique case (addr_idx)
        `ITC_IDX_QSIZE: hrdata <= {16'h0000, interrupt_queue_size_reg};
        `ITC_IDX_FLAGS: hrdata <= {18'h00000, interrupt_flags_reg};
        `ITC_IDX_MASK:  hrdata <= {16'h0000, interrupt_mask_reg};
        `ITC_IDX_TIMER: hrdata <= {16'h0000, watchdog_timer_period_reg};
        `ITC_IDX_GCFG2: hrdata <= {16'h0000, general_config_two_reg};
        `ITC_IDX_WDCMD: hrdata <= {30'h0000_0000,
                                   timer_disable_option_reg, 1'b0};
        `ITC_IDX_BASE:  hrdata <= {16'h0000, initiate_block_base_reg};
        default:        hrdata <= 32'h0000_0000;
      endcase
    end
  end

  // Queue size register with time base select.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      interrupt_queue_size_reg <= `ITC_RST_QSIZE;
    end else if (ce && wr_pend_reg && wr_idx_reg == `ITC_IDX_QSIZE) begin
      interrupt_queue_size_reg <= hwdata[15:0] & `ITC_QS_WMASK;
    end
  end

  // Mask register; only bits 13..0 are writable, the upper two stay one.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      interrupt_mask_reg <= `ITC_RST_MASK;
    end else if (ce && wr_pend_reg && wr_idx_reg == `ITC_IDX_MASK) begin
      interrupt_mask_reg <= hwdata[15:0] | ~`ITC_MASK_WMASK;
    end
  end

  // Timer period register.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      watchdog_timer_period_reg <= `ITC_RST_TIMER;
    end else if (ce && wr_pend_reg && wr_idx_reg == `ITC_IDX_TIMER) begin
      watchdog_timer_period_reg <= hwdata[15:0];
    end
  end

  // General configuration two.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      general_config_two_reg <= `ITC_RST_GCFG2;
    end else if (ce && wr_pend_reg && wr_idx_reg == `ITC_IDX_GCFG2) begin
      general_config_two_reg <= hwdata[15:0] & `ITC_G2_WMASK;
    end
  end

  // Initiate block base, segment address of the queues.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      initiate_block_base_reg <= `ITC_RST_BASE;
    end else if (ce && wr_pend_reg && wr_idx_reg == `ITC_IDX_BASE) begin
      initiate_block_base_reg <= hwdata[15:0];
    end
  end

  // Timer disable option; the reset bit of this word is a strobe only.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      timer_disable_option_reg <= 1'b0;
    end else if (ce && wr_pend_reg && wr_idx_reg == `ITC_IDX_WDCMD) begin
      timer_disable_option_reg <= hwdata[`ITC_WD_DISABLE];
    end
  end

  assign wd_clear = wr_pend_reg && wr_idx_reg == `ITC_IDX_WDCMD &&
                    hwdata[`ITC_WD_RESET];

  // Flags: a read clears them, yet an event in the same cycle still sets.
  always_comb begin
    interrupt_flags_next = read_flags ? `ITC_RST_FLAGS
                                      : interrupt_flags_reg;
    interrupt_flags_next = interrupt_flags_next | {
      events[`ITC_NFLAGS-2:`ITC_FLAG_TIM],
      timer_event,
      events[`ITC_FLAG_TIM-1:0]};
  end

  // Flag register update.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      interrupt_flags_reg <= `ITC_RST_FLAGS;
    end else if (ce) begin
      interrupt_flags_reg <= interrupt_flags_next;
    end
  end

  // Interrupt pin from unmasked flags; masking never clears a flag.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      interrupt_pin <= 1'b0;
    end else if (ce) begin
      interrupt_pin <= |(interrupt_flags_reg &
                         ~interrupt_mask_reg[`ITC_NFLAGS-1:0]);
    end
  end

  // Two-flop synchronisers for the pins.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fs_sync_reg   <= 2'b00;
      fs_last_reg   <= 1'b0;
      external_input_six_sync_reg <= 2'b00;
    end else if (ce) begin
      fs_sync_reg   <= {fs_sync_reg[0], frame_sync};
      fs_last_reg   <= fs_sync_reg[1];
      external_input_six_sync_reg <= {external_input_six_sync_reg[0], external_input_six};
    end
  end

  assign fs_rise = fs_sync_reg[1] && !fs_last_reg;

  // Tick source: every second frame sync rising edge, or a master clock divider.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fs_half_reg <= 1'b0;
      div_cnt_reg <= 15'h0000;
    end else if (ce) begin
      fs_half_reg <= fs_half_reg ^ fs_rise;
      if (div_cnt_reg == 15'(TICK_CYCLES - 1)) begin
        div_cnt_reg <= 15'h0000;
      end else begin
        div_cnt_reg <= div_cnt_reg + 15'h0001;
      end
    end
  end

  assign tick = interrupt_queue_size_reg[`ITC_QS_TIME_BASE_FRAME_SYNC_SELECT]
              ? (fs_rise && fs_half_reg)
              : (div_cnt_reg == 15'(TICK_CYCLES - 1));

  // Programmed time in ticks, never below the least time.
  always_comb begin
    limit = 15'(watchdog_timer_period_reg[15:`ITC_TM_S_LSB] *
                `ITC_TICKS_PER_S) +
            15'(watchdog_timer_period_reg[11:`ITC_TM_MS_LSB] *
                `ITC_TICKS_PER_MS) +
            15'(watchdog_timer_period_reg[1:`ITC_TM_Q_LSB]);
    if (limit < `ITC_MIN_TICKS) begin
      limit = `ITC_MIN_TICKS;
    end
  end

  // Watchdog: expires one to two ticks past the limit, then each limit.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_reg        <= 15'h0000;
      watchdog_output_pin <= 1'b0;
    end else if (ce) begin
      if (wd_clear || timer_disable_option_reg) begin
        tick_cnt_reg <= 15'h0000;
        if (tick) begin
          watchdog_output_pin <= 1'b0;
        end
      end else if (tick) begin
        if (tick_cnt_reg > limit) begin
          tick_cnt_reg        <= `ITC_REARM_TICKS;
          watchdog_output_pin <= 1'b1;
        end else begin
          tick_cnt_reg        <= tick_cnt_reg + 15'h0001;
          watchdog_output_pin <= 1'b0;
        end
      end
    end
  end

  assign timer_event = ce && tick && !wd_clear &&
                       !timer_disable_option_reg &&
                       tick_cnt_reg > limit;

  // Queue placement after the initiate block.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      queue_map <= '0;
    end else if (ce) begin
      queue_map.hdlc_words <= queue_words(
        interrupt_queue_size_reg[7:`ITC_QS_HS_LSB], `ITC_HQ_UNIT);
      queue_map.monitor_words <= queue_words(
        interrupt_queue_size_reg[4:`ITC_QS_MS_LSB], `ITC_HQ_UNIT);
      queue_map.ci_words <= queue_words(
        {1'b0, interrupt_queue_size_reg[1:`ITC_QS_CS_LSB]},
        `ITC_CQ_UNIT);
      queue_map.hdlc_start <= {initiate_block_base_reg, 8'h00} +
                              `ITC_QUEUE_OFFSET;
      queue_map.monitor_start <= {initiate_block_base_reg, 8'h00} +
        `ITC_QUEUE_OFFSET + 24'(queue_words(
        interrupt_queue_size_reg[7:`ITC_QS_HS_LSB], `ITC_HQ_UNIT));
      queue_map.ci_start <= {initiate_block_base_reg, 8'h00} +
        `ITC_QUEUE_OFFSET + 24'(queue_words(
        interrupt_queue_size_reg[7:`ITC_QS_HS_LSB], `ITC_HQ_UNIT)) +
        24'(queue_words(
        interrupt_queue_size_reg[4:`ITC_QS_MS_LSB], `ITC_HQ_UNIT));
    end
  end

  // Memory init strobe, clock select, bypass and byte order.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      memory_init_start <= 1'b0;
      config_out        <= '0;
    end else if (ce) begin
      memory_init_start <= memory_reg_write &&
                           !general_config_two_reg[`ITC_G2_SKIP_MEMORY_INIT];
      config_out <= itc_config_t'({
        general_config_two_reg[1:`ITC_G2_MC_LSB],
        general_config_two_reg[`ITC_G2_BYP],
        general_config_two_reg[`ITC_G2_D6],
        general_config_two_reg[`ITC_G2_SWAP]});
    end
  end

  // Matrix input 6 source and shared memory byte lanes.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      matrix_input_six <= 1'b0;
      memory_word      <= 16'h0000;
    end else if (ce) begin
      matrix_input_six <= general_config_two_reg[`ITC_G2_D6]
                        ? tx2_matrix_bit : external_input_six_sync_reg[1];
      memory_word <= general_config_two_reg[`ITC_G2_SWAP]
                   ? {frame_byte_pair[7:0], frame_byte_pair[15:8]}
                   : frame_byte_pair;
    end
  end

endmodule : itc_regs

/* inc/itc_map.svh */
`ifndef ITC_MAP_SVH
`define ITC_MAP_SVH

// Register indices; byte address is four times the index.
`define ITC_IDX_QSIZE    9'h036
`define ITC_IDX_FLAGS    9'h038
`define ITC_IDX_MASK     9'h03A
`define ITC_IDX_TIMER    9'h03C
`define ITC_IDX_TEST     9'h03E
`define ITC_IDX_GCFG2    9'h042
`define ITC_IDX_WDCMD    9'h044
`define ITC_IDX_BASE     9'h046

// Reset values.
`define ITC_RST_QSIZE    16'h0000
`define ITC_RST_FLAGS    14'h0000
`define ITC_RST_MASK     16'hFFFF
`define ITC_RST_TIMER    16'h0800
`define ITC_RST_GCFG2    16'h0000
`define ITC_RST_BASE     16'h0000

// Queue size register fields.
`define ITC_QS_TIME_BASE_FRAME_SYNC_SELECT      15
`define ITC_QS_HS_LSB    5
`define ITC_QS_MS_LSB    2
`define ITC_QS_CS_LSB    0
`define ITC_QS_WMASK     16'h80FF

// Interrupt flag positions.
`define ITC_NFLAGS       14
`define ITC_FLAG_TIM     11
`define ITC_MASK_WMASK   16'h3FFF

// Timer register fields.
`define ITC_TM_S_LSB     12
`define ITC_TM_MS_LSB    2
`define ITC_TM_Q_LSB     0
`define ITC_TICKS_PER_S  15'h0FA0
`define ITC_TICKS_PER_MS 15'h0004
`define ITC_MIN_TICKS    15'h0004
`define ITC_REARM_TICKS  15'h0002

// General configuration two fields.
`define ITC_G2_MC_LSB    0
`define ITC_G2_SKIP_MEMORY_INIT     3
`define ITC_G2_BYP       4
`define ITC_G2_D6        5
`define ITC_G2_SWAP      6
`define ITC_G2_WMASK     16'h007B

// Watchdog command register bits.
`define ITC_WD_RESET     0
`define ITC_WD_DISABLE   1

// Queue layout in words.
`define ITC_QUEUE_OFFSET 24'h000100
`define ITC_HQ_UNIT      11'h080
`define ITC_CQ_UNIT      11'h040

// Counter clock: tick period and system clock rate.
`define ITC_TICK_US      250
`define ITC_CLK_MHZ      125

`endif

/* inc/itc_pkg.sv */
package itc_pkg;

  // Event strobes from the HDLC, DMA, monitor and C/I engines.
  typedef struct packed {
    logic fault_counter_overflow_flag;
    logic prbs_recovered_flag;
    logic event_fifo_overload_flag;
    logic event_fifo_warning_flag;
    logic tx_fifo_overload_flag;
    logic tx_fifo_warning_flag;
    logic rx_fifo_overload_flag;
    logic rx_fifo_warning_flag;
    logic circular_overload_flag;
    logic monitor_transmit_flag;
    logic monitor_receive_flag;
    logic ci_receive_flag;
    logic hdlc_status_flag;
  } itc_events_t;

  // Start word addresses and sizes of the three interrupt queues.
  typedef struct packed {
    logic [23:0] hdlc_start;
    logic [10:0] hdlc_words;
    logic [23:0] monitor_start;
    logic [10:0] monitor_words;
    logic [23:0] ci_start;
    logic [10:0] ci_words;
  } itc_queue_map_t;

  // Settings handed to the memory interface and matrix.
  typedef struct packed {
    logic [1:0] master_clock_select;
    logic       buffer_bypass;
    logic       second_tx_matrix_route;
    logic       swap;
  } itc_config_t;

endpackage : itc_pkg

/* tb/itc_regs_chk.sv */
module itc_regs_chk
  import itc_pkg::*;
#(
  parameter int TICK_CYCLES = 8
) (
  // Clock and reset.
  input wire logic           clock,
  input wire logic           nrst,
  // Observed inputs.
  input wire logic           memory_reg_write,
  input wire logic [15:0]    frame_byte_pair,
  input wire logic           tx2_matrix_bit,
  input wire logic           external_input_six,
  // Observed outputs.
  input wire logic           watchdog_output_pin,
  input wire logic           memory_init_start,
  input wire logic           matrix_input_six,
  input wire logic [15:0]    memory_word,
  input wire itc_queue_map_t queue_map,
  input wire itc_config_t    config_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  int unsigned wd_len;

  // Counts the cycles of the present watchdog pulse.
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wd_len <= 0;
    end else if (!watchdog_output_pin) begin
      wd_len <= 0;
    end else begin
      wd_len <= wd_len + 1;
    end
  end

  // The end of a watchdog pulse.
  sequence s_wdo_end;
    $fell(watchdog_output_pin);
  endsequence

  AST_HDLC_QUEUE: assert property ($past(nrst) |->
    queue_map.hdlc_words[6:0] == 7'h00 && queue_map.hdlc_start[7:0] == 8'h00
    && queue_map.hdlc_words != 11'h000 && queue_map.hdlc_words <= 11'h400)
    else $error("hdlc queue layout wrong");
  AST_MON_QUEUE: assert property ($past(nrst) |->
    queue_map.monitor_start == queue_map.hdlc_start + queue_map.hdlc_words
    && queue_map.monitor_words[6:0] == 7'h00
    && queue_map.monitor_words != 11'h000)
    else $error("monitor queue layout wrong");
  AST_CI_QUEUE: assert property ($past(nrst) |->
    queue_map.ci_start == queue_map.monitor_start + queue_map.monitor_words
    && queue_map.ci_words[5:0] == 6'h00 && queue_map.ci_words != 11'h000
    && queue_map.ci_words <= 11'h100)
    else $error("ci queue layout wrong");
  AST_WDO_WIDTH: assert property (s_wdo_end |-> wd_len >= TICK_CYCLES)
    else $error("watchdog pulse too short");
  AST_INIT_CAUSE: assert property (
    memory_init_start |-> $past(memory_reg_write))
    else $error("memory init without register write");
  AST_ROUTE: assert property (
    $past(nrst) && config_out.second_tx_matrix_route
    |-> matrix_input_six == $past(tx2_matrix_bit))
    else $error("matrix input six not from transmit two");
  AST_EXTERNAL_INPUT_SIX: assert property (
    $past(nrst, 3) && !config_out.second_tx_matrix_route
    |-> matrix_input_six == $past(external_input_six, 3))
    else $error("matrix input six not from the synchronised pin");
  AST_SWAP: assert property ($past(nrst) && config_out.swap |->
    memory_word == {$past(frame_byte_pair[7:0]), $past(frame_byte_pair[15:8])})
    else $error("swapped byte lanes wrong");
  AST_NOSWAP: assert property ($past(nrst) && !config_out.swap |->
    memory_word == $past(frame_byte_pair))
    else $error("straight byte lanes wrong");
endmodule : itc_regs_chk

bind itc_regs itc_regs_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .clock(clock), .nrst(nrst), .memory_reg_write(memory_reg_write),
  .frame_byte_pair(frame_byte_pair), .tx2_matrix_bit(tx2_matrix_bit),
  .external_input_six(external_input_six),
  .watchdog_output_pin(watchdog_output_pin),
  .memory_init_start(memory_init_start), .matrix_input_six(matrix_input_six),
  .memory_word(memory_word), .queue_map(queue_map), .config_out(config_out));

/* tb/tb_interrupt_timer_config.sv */
`define TB_CHK(g, e) \
  begin \
    comparisons++; \
    if ((g) !== (e)) begin \
      errors++; \
      $display("CHECK FAILED %0t got %0h exp %0h", $time, g, e); \
    end \
  end

module tb_interrupt_timer_config
  import itc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TICK = 8;
  logic        clock, nrst, ce, hsel, hwrite, hreadyout, hresp, fs_en;
  logic        memory_reg_write, tx2_matrix_bit, frame_sync, wd_seen;
  logic        external_input_six, interrupt_pin, watchdog_output_pin;
  logic        memory_init_start, matrix_input_six;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [15:0] frame_byte_pair, memory_word, q, b, g;
  logic [31:0] haddr, hwdata, hrdata, rd;
  itc_events_t    events;
  itc_queue_map_t queue_map;
  itc_config_t    config_out, exp_cfg;
  int          errors, comparisons, cyc, seed, n, j, f;

  itc_regs #(.TICK_CYCLES(TICK)) u_dut (
    .clock(clock), .nrst(nrst), .ce(ce), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .events(events), .memory_reg_write(memory_reg_write),
    .frame_byte_pair(frame_byte_pair), .tx2_matrix_bit(tx2_matrix_bit),
    .frame_sync(frame_sync), .external_input_six(external_input_six),
    .interrupt_pin(interrupt_pin), .watchdog_output_pin(watchdog_output_pin),
    .memory_init_start(memory_init_start),
    .matrix_input_six(matrix_input_six), .memory_word(memory_word),
    .queue_map(queue_map), .config_out(config_out));

  // Prints the counts and the verdict, then stops the run.
  task automatic wrap_up();
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : wrap_up

  // One single AHB-Lite transfer; read data lands in rd.
  task automatic ahb(input logic w, input logic [31:0] a, d);
    @(posedge clock);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : ahb

  // Reads a register and compares it with the expected low half.
  task automatic rchk(input logic [31:0] a, input logic [15:0] e);
    ahb(1'b0, a, 32'h0);
    `TB_CHK(rd, {16'h0000, e})
    `TB_CHK(hresp, 1'b0)
  endtask : rchk

  // Queue layout expected from a size word and a base segment.
  function automatic itc_queue_map_t exp_map(logic [15:0] s, logic [15:0] k);
    exp_map.hdlc_words = (11'(s[7:5]) + 11'h001) * 11'h080;
    exp_map.monitor_words = (11'(s[4:2]) + 11'h001) * 11'h080;
    exp_map.ci_words = (11'(s[1:0]) + 11'h001) * 11'h040;
    exp_map.hdlc_start = {k, 8'h00} + 24'h000100;
    exp_map.monitor_start = exp_map.hdlc_start + 24'(exp_map.hdlc_words);
    exp_map.ci_start = exp_map.monitor_start + 24'(exp_map.monitor_words);
  endfunction : exp_map

  // Times a watchdog expiry at the least limit, then keeps it cleared.
  task automatic wd(input logic time_base_frame_sync_select, input int per);
    ahb(1'b1, 32'h110, 32'h3);
    ahb(1'b1, 32'hD8, {16'h0000, time_base_frame_sync_select, 15'h0000});
    ahb(1'b1, 32'hF0, 32'h4);
    ahb(1'b1, 32'h110, 32'h1);
    n = 0;
    while (watchdog_output_pin !== 1'b1 && n < 400) begin
      @(posedge clock);
      n++;
    end
    `TB_CHK(n >= 5 * per - 2 && n <= 6 * per + 6, 1'b1)
    rchk(32'hE0, 16'h0800);
    while (watchdog_output_pin !== 1'b0) @(posedge clock);
    wd_seen = 1'b0;
    repeat (8) begin
      ahb(1'b1, 32'h110, 32'h1);
      repeat (2 * per) @(posedge clock);
    end
    `TB_CHK(wd_seen, 1'b0)
  endtask : wd

  always #4 clock = ~clock;

  // Random data inputs, frame sync, watchdog watch and the hang limit.
  always @(posedge clock) begin
    frame_byte_pair <= 16'($random(seed));
    tx2_matrix_bit <= 1'($random(seed));
    external_input_six <= 1'($random(seed));
    cyc <= cyc + 1;
    if (fs_en && cyc % 8 == 0) begin
      frame_sync <= ~frame_sync;
    end
    if (watchdog_output_pin === 1'b1) begin
      wd_seen <= 1'b1;
    end
    if (cyc == 60000) begin
      errors = errors + 1;
      wrap_up();
    end
  end

  // Main sequence of scenarios.
  initial begin
    {clock, nrst, hsel, hwrite, htrans, haddr, hwdata} = '0;
    {memory_reg_write, tx2_matrix_bit, frame_sync, fs_en} = '0;
    {external_input_six, frame_byte_pair, wd_seen} = '0;
    {errors, comparisons, cyc} = '0;
    events = '0;
    ce = 1'b1;
    hsize = 3'h2;
    seed = 31702;
    repeat (20) @(posedge clock);
    nrst <= 1'b1;
    rchk(32'hD8, 16'h0000);
    rchk(32'hE0, 16'h0000);
    rchk(32'hE8, 16'hFFFF);
    rchk(32'hF0, 16'h0800);
    rchk(32'h108, 16'h0000);
    rchk(32'h1FC, 16'h0000);
    ahb(1'b1, 32'hE0, 32'hFFFF);
    rchk(32'hE0, 16'h0000);
    for (int i = 0; i < 5; i++) begin
      q = i == 0 ? 16'hFFFF : i == 1 ? 16'h0000 : 16'($random(seed));
      b = 16'($random(seed));
      ahb(1'b1, 32'hD8, {16'h0000, q});
      ahb(1'b1, 32'h118, {16'h0000, b});
      rchk(32'hD8, q & 16'h80FF);
      @(posedge clock);
      `TB_CHK(queue_map, exp_map(q, b))
    end
    for (j = 0; j < 13; j++) begin
      f = j < 11 ? j : j + 1;
      events <= itc_events_t'(13'h0001 << j);
      @(posedge clock);
      events <= '0;
      rchk(32'hE0, 16'h0001 << f);
      `TB_CHK(interrupt_pin, 1'b0)
      rchk(32'hE0, 16'h0000);
    end
    ahb(1'b1, 32'hE8, 32'h0);
    j = {$random(seed)} % 13;
    f = j < 11 ? j : j + 1;
    events <= itc_events_t'(13'h0001 << j);
    @(posedge clock);
    events <= '0;
    repeat (4) @(posedge clock);
    `TB_CHK(interrupt_pin, 1'b1)
    ahb(1'b1, 32'hE8, 32'h1 << f);
    repeat (3) @(posedge clock);
    `TB_CHK(interrupt_pin, 1'b0)
    rchk(32'hE0, 16'h0001 << f);
    rchk(32'hE8, 16'hC000 | (16'h0001 << f));
    for (int i = 0; i < 3; i++) begin
      g = i == 0 ? 16'hFFFF : i == 1 ? 16'h0000 : 16'($random(seed));
      exp_cfg = itc_config_t'({g[1:0], g[4], g[5], g[6]});
      ahb(1'b1, 32'h108, {16'h0000, g});
      rchk(32'h108, g & 16'h007B);
      @(posedge clock);
      `TB_CHK(config_out, exp_cfg)
      memory_reg_write <= 1'b1;
      @(posedge clock);
      memory_reg_write <= 1'b0;
      n = 0;
      repeat (3) begin
        @(posedge clock);
        if (memory_init_start === 1'b1) begin
          n++;
        end
      end
      `TB_CHK(n, g[3] ? 0 : 1)
    end
    wd(1'b0, TICK);
    fs_en = 1'b1;
    wd(1'b1, 32);
    wrap_up();
  end
endmodule : tb_interrupt_timer_config
